/* File: common/mgr_pkg.sv */
package mgr_pkg;
  // Register addresses (index form, plain port)
  localparam logic [7:0] ADDR_MAC_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_B2B_GAP = 8'h02;
  localparam logic [7:0] ADDR_NB2B_GAP = 8'h03;
  localparam logic [7:0] ADDR_CW_RETRY = 8'h04;
  localparam logic [7:0] ADDR_FRAME_LIMIT = 8'h05;
  localparam logic [7:0] ADDR_STATION_LOW = 8'h10;
  localparam logic [7:0] ADDR_STATION_MID = 8'h11;
  localparam logic [7:0] ADDR_STATION_HIGH = 8'h12;
  localparam logic [7:0] ADDR_TX_STATUS = 8'h20;
  localparam logic [7:0] ADDR_RX_STATUS = 8'h21;
  // Reset values
  localparam logic [15:0] RST_B2B_GAP = 16'h0000;
  localparam logic [15:0] RST_NB2B_GAP = 16'h0000;
  localparam logic [15:0] RST_CW_RETRY = 16'h370f;
  localparam logic [15:0] RST_FRAME_LIMIT = 16'h0600;
  localparam logic [15:0] RST_CONFIG = 16'h0000;
  // Writable bit masks; all others read zero
  localparam logic [15:0] MASK_B2B_GAP = 16'h007f;
  localparam logic [15:0] MASK_NB2B_GAP = 16'h7f7f;
  localparam logic [15:0] MASK_CW_RETRY = 16'h3f0f;
  localparam logic [15:0] MASK_CONFIG = 16'h0001;
  // Field positions
  localparam int CSW_LSB = 8;
  localparam int CW_LSB = 8;
  // Gap offsets in time units
  localparam logic [7:0] GAP_ADD_FULL = 8'h03;
  localparam logic [7:0] GAP_ADD_HALF = 8'h06;
  // Time unit 0.46 us = 460 ns
  localparam int UNIT_NS = 460;
  localparam int CLK_NS = 25;
  localparam int UNIT_CYC = UNIT_NS / CLK_NS;
  // One byte at 10 Mb/s = 800 ns
  localparam int BYTE_NS = 800;
  localparam int BYTE_CYC = BYTE_NS / CLK_NS;
endpackage : mgr_pkg

/* File: rtl/mgr_tick.sv */
`timescale 1ns/100ps
module mgr_tick #(
  parameter int DIV = 18
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Control
  input wire logic clear,
  output logic tick
);
  // Counter is sixteen bits wide, so the divider must fit in it
  if (DIV < 1 || DIV > 65536)
  begin : g_div_check
    $error("DIV out of range");
  end
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic next_tick;
  always_comb
  begin
    next_cnt = cnt + 16'h0001;
    next_tick = 1'b0;
    if (clear)
    begin
      next_cnt = 16'h0000;
    end
    else if (cnt == 16'(DIV - 1))
    begin
      next_cnt = 16'h0000;
      next_tick = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : mgr_tick

/* File: rtl/mgr_config.sv */
`timescale 1ns/100ps
module mgr_config
  import mgr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Transmit path
  input wire logic tx_request,
  input wire logic tx_collision,
  input wire logic tx_end,
  input wire logic tx_back_to_back,
  output logic tx_go,
  output logic tx_abort,
  output logic tx_late_collision,
  // Receive path
  input wire logic rx_byte,
  input wire logic rx_end,
  output logic rx_oversize,
  // Configuration out
  output logic [47:0] station_address,
  output logic full_duplex_select
);
  import mgr_pkg::*;
  logic [15:0] back_to_back_gap, non_back_to_back_gap, collision_window_retry_limit;
  logic [15:0] receive_frame_limit, mac_config;
  logic [15:0] station_address_low, station_address_mid, station_address_high;
  logic [15:0] next_reg [8];
  logic unit_tick;
  logic [7:0] gap_cnt, next_gap_cnt;
  logic [15:0] byte_cnt, next_byte_cnt;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [3:0] retry_cnt, next_retry_cnt;
  logic [5:0] byte_div, next_byte_div;
  logic gap_clear;
  logic next_tx_go, next_tx_abort, next_late, next_rx_oversize;
  logic [15:0] next_rdata;
  logic [15:0] tx_status, next_tx_status, rx_status, next_rx_status;
  logic [6:0] carrier_sense_window, non_b2b, b2b;
  logic [5:0] collision_window;
  logic [3:0] retransmit_limit;
  logic [7:0] gap_target;
  typedef enum logic [1:0] {
    MGR_IDLE = 2'b00,
    MGR_GAP = 2'b01,
    MGR_SEND = 2'b10
  } mgr_state_e;
  mgr_state_e state, next_state;

  assign b2b = back_to_back_gap[6:0];
  assign carrier_sense_window = non_back_to_back_gap[CSW_LSB +: 7];
  assign non_b2b = non_back_to_back_gap[6:0];
  assign collision_window = collision_window_retry_limit[CW_LSB +: 6];
  assign retransmit_limit = collision_window_retry_limit[3:0];

  // Register writes, reserved bits forced to zero
  always_comb
  begin
    next_reg[0] = back_to_back_gap;
    next_reg[1] = non_back_to_back_gap;
    next_reg[2] = collision_window_retry_limit;
    next_reg[3] = receive_frame_limit;
    next_reg[4] = station_address_low;
    next_reg[5] = station_address_mid;
    next_reg[6] = station_address_high;
    next_reg[7] = mac_config;
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_B2B_GAP: next_reg[0] = reg_wdata & MASK_B2B_GAP;
        ADDR_NB2B_GAP: next_reg[1] = reg_wdata & MASK_NB2B_GAP;
        ADDR_CW_RETRY: next_reg[2] = reg_wdata & MASK_CW_RETRY;
        ADDR_FRAME_LIMIT: next_reg[3] = reg_wdata;
        ADDR_STATION_LOW: next_reg[4] = reg_wdata;
        ADDR_STATION_MID: next_reg[5] = reg_wdata;
        ADDR_STATION_HIGH: next_reg[6] = reg_wdata;
        ADDR_MAC_CONFIG: next_reg[7] = reg_wdata & MASK_CONFIG;
        default: next_reg[0] = back_to_back_gap;
      endcase
    end
  end

  // Read mux; unmapped reads zero
  always_comb
  begin
    next_rdata = 16'h0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_B2B_GAP: next_rdata = back_to_back_gap;
        ADDR_NB2B_GAP: next_rdata = non_back_to_back_gap;
        ADDR_CW_RETRY: next_rdata = collision_window_retry_limit;
        ADDR_FRAME_LIMIT: next_rdata = receive_frame_limit;
        ADDR_STATION_LOW: next_rdata = station_address_low;
        ADDR_STATION_MID: next_rdata = station_address_mid;
        ADDR_STATION_HIGH: next_rdata = station_address_high;
        ADDR_MAC_CONFIG: next_rdata = mac_config;
        ADDR_TX_STATUS: next_rdata = tx_status;
        ADDR_RX_STATUS: next_rdata = rx_status;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // Gap target depends on duplex and back-to-back kind
  always_comb
  begin
    if (!tx_back_to_back)
      gap_target = {1'b0, non_b2b};
    else if (mac_config[0])
      gap_target = {1'b0, b2b} + GAP_ADD_FULL;
    else
      gap_target = {1'b0, b2b} + GAP_ADD_HALF;
  end

  mgr_tick #(.DIV(UNIT_CYC)) u_unit (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clear(gap_clear),
    .tick(unit_tick)
  );

  // Transmit sequencing: gap, send, retry accounting
  always_comb
  begin
    next_state = state;
    next_gap_cnt = gap_cnt;
    next_byte_cnt = byte_cnt;
    next_byte_div = byte_div;
    next_retry_cnt = retry_cnt;
    next_tx_go = 1'b0;
    next_tx_abort = 1'b0;
    next_late = 1'b0;
    next_tx_status = tx_status;
    gap_clear = 1'b0;
    unique case (state)
      MGR_IDLE:
      begin
        gap_clear = 1'b1;
        next_gap_cnt = 8'h00;
        if (tx_request)
          next_state = MGR_GAP;
      end
      MGR_GAP:
      begin
        if (unit_tick)
          next_gap_cnt = gap_cnt + 8'h01;
        if (gap_cnt >= gap_target)
        begin
          next_state = MGR_SEND;
          next_tx_go = 1'b1;
          next_byte_cnt = 16'h0000;
          next_byte_div = 6'h00;
        end
      end
      MGR_SEND:
      begin
        if (byte_div == 6'(BYTE_CYC - 1))
        begin
          next_byte_div = 6'h00;
          next_byte_cnt = byte_cnt + 16'h0001;
        end
        else
          next_byte_div = byte_div + 6'h01;
        if (tx_collision)
        begin
          if (byte_cnt > {10'h000, collision_window})
          begin
            next_late = 1'b1;
            next_tx_status[1] = 1'b1;
          end
          if (retry_cnt >= retransmit_limit)
          begin
            next_tx_abort = 1'b1;
            next_tx_status[0] = 1'b1;
            next_retry_cnt = 4'h0;
            next_state = MGR_IDLE;
          end
          else
          begin
            next_retry_cnt = retry_cnt + 4'h1;
            next_state = MGR_GAP;
          end
          next_gap_cnt = 8'h00;
          gap_clear = 1'b1;
        end
        else if (tx_end)
        begin
          next_retry_cnt = 4'h0;
          next_state = MGR_IDLE;
        end
      end
      default: next_state = MGR_IDLE;
    endcase
    if (reg_rd && reg_addr == ADDR_TX_STATUS)
      next_tx_status = {14'h0000, next_tx_abort, next_late} | (next_tx_status & 16'h0000);
  end

  // Receive length check
  always_comb
  begin
    next_rx_cnt = rx_cnt;
    next_rx_oversize = 1'b0;
    next_rx_status = rx_status;
    if (rx_byte)
      next_rx_cnt = rx_cnt + 16'h0001;
    if (rx_end)
    begin
      next_rx_cnt = 16'h0000;
      if (rx_cnt > receive_frame_limit)
        next_rx_oversize = 1'b1;
    end
    if (reg_rd && reg_addr == ADDR_RX_STATUS)
      next_rx_status = 16'h0000;
    if (next_rx_oversize)
      next_rx_status[0] = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      back_to_back_gap <= RST_B2B_GAP;
      non_back_to_back_gap <= RST_NB2B_GAP;
      collision_window_retry_limit <= RST_CW_RETRY;
      receive_frame_limit <= RST_FRAME_LIMIT;
      station_address_low <= 16'h0000;
      station_address_mid <= 16'h0000;
      station_address_high <= 16'h0000;
      mac_config <= RST_CONFIG;
      reg_rdata <= 16'h0000;
      state <= MGR_IDLE;
      gap_cnt <= 8'h00;
      byte_cnt <= 16'h0000;
      byte_div <= 6'h00;
      retry_cnt <= 4'h0;
      tx_go <= 1'b0;
      tx_abort <= 1'b0;
      tx_late_collision <= 1'b0;
      tx_status <= 16'h0000;
      rx_cnt <= 16'h0000;
      rx_oversize <= 1'b0;
      rx_status <= 16'h0000;
      station_address <= 48'h0000_0000_0000;
      full_duplex_select <= 1'b0;
    end
    else
    begin
      back_to_back_gap <= next_reg[0];
      non_back_to_back_gap <= next_reg[1];
      collision_window_retry_limit <= next_reg[2];
      receive_frame_limit <= next_reg[3];
      station_address_low <= next_reg[4];
      station_address_mid <= next_reg[5];
      station_address_high <= next_reg[6];
      mac_config <= next_reg[7];
      reg_rdata <= next_rdata;
      state <= next_state;
      gap_cnt <= next_gap_cnt;
      byte_cnt <= next_byte_cnt;
      byte_div <= next_byte_div;
      retry_cnt <= next_retry_cnt;
      tx_go <= next_tx_go;
      tx_abort <= next_tx_abort;
      tx_late_collision <= next_late;
      tx_status <= next_tx_status;
      rx_cnt <= next_rx_cnt;
      rx_oversize <= next_rx_oversize;
      rx_status <= next_rx_status;
      // Byte one is most significant on the wire
      station_address <= {next_reg[6][7:0], next_reg[6][15:8],
                          next_reg[5][7:0], next_reg[5][15:8],
                          next_reg[4][7:0], next_reg[4][15:8]};
      full_duplex_select <= next_reg[7][0];
    end
  end

  // Checks
  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    (back_to_back_gap & ~MASK_B2B_GAP) == 16'h0000 &&
    (collision_window_retry_limit & ~MASK_CW_RETRY) == 16'h0000)
    else $error("Reserved bits not zero");
  a_read_data: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_FRAME_LIMIT && !reg_wr |=> reg_rdata == $past(receive_frame_limit))
    else $error("Frame limit readback wrong");
  a_go_gap: assert property (@(posedge ref_clk) disable iff (!nrst)
    state == MGR_GAP && next_state == MGR_SEND |-> gap_cnt >= gap_target)
    else $error("Transmit started before gap");
  a_full_gap: assert property (@(posedge ref_clk) disable iff (!nrst)
    tx_back_to_back && mac_config[0] |-> gap_target == {1'b0, b2b} + 8'h03)
    else $error("Full duplex gap wrong");
  a_half_gap: assert property (@(posedge ref_clk) disable iff (!nrst)
    tx_back_to_back && !mac_config[0] |-> gap_target == {1'b0, b2b} + 8'h06)
    else $error("Half duplex gap wrong");
  a_nb2b_gap: assert property (@(posedge ref_clk) disable iff (!nrst)
    !tx_back_to_back |-> gap_target == {1'b0, non_b2b})
    else $error("Non back to back gap wrong");
  a_abort_limit: assert property (@(posedge ref_clk) disable iff (!nrst)
    state == MGR_SEND && tx_collision && retry_cnt >= retransmit_limit |=> tx_abort && state == MGR_IDLE)
    else $error("Missing abort at retry limit");
  a_late_coll: assert property (@(posedge ref_clk) disable iff (!nrst)
    tx_late_collision |-> $past(byte_cnt) > {10'h000, $past(collision_window)})
    else $error("Late collision inside window");
  a_oversize: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_end |=> rx_oversize == ($past(rx_cnt) > $past(receive_frame_limit)))
    else $error("Oversize flag wrong");
  a_duplex_out: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_wr && reg_addr == ADDR_MAC_CONFIG |=> full_duplex_select == $past(reg_wdata[0]))
    else $error("Duplex output not updated");
  a_addr_order: assert property (@(posedge ref_clk) disable iff (!nrst)
    station_address[7:0] == station_address_low[15:8] &&
    station_address[47:40] == station_address_high[7:0])
    else $error("Station address byte order");
endmodule : mgr_config

/* File: verification/mgr_link_model.sv */
`timescale 1ns/100ps
module mgr_link_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Transmit side
  input wire logic tx_go,
  input wire logic coll_load,
  input wire logic [3:0] coll_count,
  input wire logic [11:0] coll_delay,
  output logic tx_collision,
  output logic tx_end,
  // Receive side
  input wire logic rx_start,
  input wire logic [15:0] rx_len,
  output logic rx_byte,
  output logic rx_end
);
  int left;
  initial
  begin
    tx_collision = 1'b0;
    tx_end = 1'b0;
    left = 0;
    forever
    begin
      @(posedge ref_clk);
      if (coll_load === 1'b1)
        left = coll_count;
      if (tx_go === 1'b1)
      begin
        // Collide on the first attempts, then finish with a short body
        repeat ((left > 0) ? coll_delay : 12'h003) @(posedge ref_clk);
        if (left > 0)
          tx_collision <= 1'b1;
        else
          tx_end <= 1'b1;
        left = (left > 0) ? left - 1 : 0;
        @(posedge ref_clk);
        tx_collision <= 1'b0;
        tx_end <= 1'b0;
      end
    end
  end
  initial
  begin
    rx_byte = 1'b0;
    rx_end = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      if (rx_start === 1'b1)
      begin
        // One byte strobe every other cycle, as a slow line would give
        repeat (rx_len)
        begin
          rx_byte <= 1'b1;
          @(posedge ref_clk);
          rx_byte <= 1'b0;
          @(posedge ref_clk);
        end
        rx_end <= 1'b1;
        @(posedge ref_clk);
        rx_end <= 1'b0;
      end
    end
  end
endmodule : mgr_link_model

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import mgr_pkg::*;
  // Bus and control
  logic ref_clk, nrst, reg_wr, reg_rd, tx_request, tx_back_to_back, coll_load, rx_start;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rx_len;
  logic [3:0] coll_count;
  logic [11:0] coll_delay;
  // Design and link outputs
  logic tx_collision, tx_end, tx_go, tx_abort, tx_late_collision, rx_byte, rx_end, rx_oversize;
  logic full_duplex_select;
  logic [47:0] station_address;
  int n_errors = 0;
  int compares = 0;
  logic [7:0] ra [6] = '{ADDR_B2B_GAP, ADDR_NB2B_GAP, ADDR_CW_RETRY, ADDR_FRAME_LIMIT,
    ADDR_STATION_LOW, ADDR_STATION_MID};
  logic [15:0] rv [6] = '{RST_B2B_GAP, RST_NB2B_GAP, RST_CW_RETRY, RST_FRAME_LIMIT, 16'h0000, 16'h0000};
  logic [15:0] rm [6] = '{MASK_B2B_GAP, MASK_NB2B_GAP, MASK_CW_RETRY, 16'hffff, 16'hffff, 16'hffff};
  mgr_config dut_u (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_request(tx_request),
    .tx_collision(tx_collision), .tx_end(tx_end), .tx_back_to_back(tx_back_to_back), .tx_go(tx_go),
    .tx_abort(tx_abort), .tx_late_collision(tx_late_collision), .rx_byte(rx_byte), .rx_end(rx_end),
    .rx_oversize(rx_oversize), .station_address(station_address), .full_duplex_select(full_duplex_select));
  mgr_link_model link_u (.ref_clk(ref_clk), .nrst(nrst), .tx_go(tx_go), .coll_load(coll_load),
    .coll_count(coll_count), .coll_delay(coll_delay), .tx_collision(tx_collision), .tx_end(tx_end),
    .rx_start(rx_start), .rx_len(rx_len), .rx_byte(rx_byte), .rx_end(rx_end));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop;
    $display("Counts: compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial
  begin
    // Longest legal run is well under this
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    report_and_stop();
  end
  task automatic ok(input bit c, input string msg);
    compares++;
    if (!c)
    begin
      n_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : ok
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // Registered outputs settle after the taking edge
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd
  function automatic int exp_gap(input logic dup, input logic b2b, input logic [6:0] f);
    if (!b2b)
      return int'(f) * UNIT_CYC;
    return (int'(f) + int'(dup ? GAP_ADD_FULL : GAP_ADD_HALF)) * UNIT_CYC;
  endfunction : exp_gap
  function automatic logic [47:0] exp_station(input logic [15:0] l, m, h);
    return {h[7:0], h[15:8], m[7:0], m[15:8], l[7:0], l[15:8]};
  endfunction : exp_station
  // Runs one frame; the request drops after attempt fin, the last one expected
  task automatic frame(input int n, input int fin, output int gos, output int first, output bit ab,
    output bit late);
    int cyc;
    bit fin_seen;
    cyc = 0;
    gos = 0;
    first = 0;
    ab = 0;
    late = 0;
    fin_seen = 0;
    @(posedge ref_clk);
    coll_load <= 1'b1;
    coll_count <= 4'(n);
    @(posedge ref_clk);
    coll_load <= 1'b0;
    tx_request <= 1'b1;
    while (!fin_seen && cyc < 20000)
    begin
      @(negedge ref_clk);
      cyc++;
      late |= (tx_late_collision === 1'b1);
      ab |= (tx_abort === 1'b1);
      fin_seen = (tx_end === 1'b1) || ab;
      if (tx_go === 1'b1)
      begin
        gos++;
        if (gos == 1)
          first = cyc;
        if (gos == fin)
          @(posedge ref_clk) tx_request <= 1'b0;
      end
    end
    ok(fin_seen, "frame never finished");
  endtask : frame
  task automatic gap(input logic dup, input logic b2b, input logic [6:0] f);
    int gos, first, ex;
    bit ab, late;
    ex = exp_gap(dup, b2b, f);
    wr(ADDR_MAC_CONFIG, {15'h0000, dup});
    ok(full_duplex_select === dup, "duplex select");
    if (b2b)
      wr(ADDR_B2B_GAP, {9'h000, f});
    else
      wr(ADDR_NB2B_GAP, {1'b0, f >> 1, 1'b0, f});
    @(posedge ref_clk) tx_back_to_back <= b2b;
    frame(0, 1, gos, first, ab, late);
    ok(first >= ex && first <= ex + 4, "gap length");
  endtask : gap
  task automatic rx_frame(input logic [15:0] len, input logic exp);
    int cyc;
    cyc = 0;
    @(posedge ref_clk);
    rx_len <= len;
    rx_start <= 1'b1;
    @(posedge ref_clk);
    rx_start <= 1'b0;
    while (rx_end !== 1'b1 && cyc < 9000)
    begin
      @(negedge ref_clk);
      cyc++;
    end
    ok(cyc < 9000, "receive frame hung");
    @(negedge ref_clk);
    ok(rx_oversize === exp, "oversize flag");
  endtask : rx_frame
  initial
  begin
    logic [15:0] v, l, m, h;
    int gos, first, lim, fin;
    bit ab, late;
    nrst = 1'b0;
    {reg_wr, reg_rd, tx_request, tx_back_to_back, coll_load, rx_start} = 6'h00;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    rx_len = 16'h0000;
    coll_count = 4'h0;
    coll_delay = 12'h005;
    void'($urandom(32'hd19b));
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd(ra[i], v);
      ok(v === rv[i], "reset value");
      wr(ra[i], 16'($urandom));
      wr(ra[i], reg_wdata);
      rd(ra[i], v);
      ok(v === (reg_wdata & rm[i]), "read back");
    end
    wr(8'h33, 16'hffff);
    rd(8'h33, v);
    ok(v === 16'h0000, "unmapped read");
    $display("Test done: registers");
    l = 16'($urandom);
    m = 16'($urandom);
    h = 16'($urandom);
    wr(ADDR_STATION_LOW, l);
    wr(ADDR_STATION_MID, m);
    wr(ADDR_STATION_HIGH, h);
    ok(station_address === exp_station(l, m, h), "station address");
    $display("Test done: station address");
    gap(1'b0, 1'b1, 7'h12);
    gap(1'b1, 1'b1, 7'h15);
    for (int i = 0; i < 4; i++)
      gap(i[0], i[1], 7'(1 + $urandom % 12));
    $display("Test done: gaps");
    for (int i = 0; i < 2; i++)
    begin
      lim = (i == 0) ? 0 : 1 + $urandom % 4;
      wr(ADDR_CW_RETRY, 16'h3700 | 16'(lim));
      for (int n = lim; n <= lim + 1; n++)
      begin
        fin = ((n > lim) ? lim : n) + 1;
        frame(n, fin, gos, first, ab, late);
        ok(gos == fin && ab == (n > lim), "retry count");
      end
    end
    rd(ADDR_TX_STATUS, v);
    ok(v[0] === 1'b1, "abort status");
    $display("Test done: retries");
    wr(ADDR_CW_RETRY, 16'h020f);
    @(posedge ref_clk) coll_delay <= 12'h190;
    frame(1, 2, gos, first, ab, late);
    ok(late, "late collision missed");
    rd(ADDR_TX_STATUS, v);
    ok(v[1] === 1'b1, "late status");
    @(posedge ref_clk) coll_delay <= 12'h005;
    frame(1, 2, gos, first, ab, late);
    ok(!late, "early collision flagged late");
    $display("Test done: collision window");
    wr(ADDR_FRAME_LIMIT, 16'h0600);
    rx_frame(16'h0600, 1'b0);
    rx_frame(16'h0601, 1'b1);
    wr(ADDR_FRAME_LIMIT, 16'h05ee);
    rx_frame(16'h05ef, 1'b1);
    lim = 20 + $urandom % 40;
    wr(ADDR_FRAME_LIMIT, 16'(lim));
    rx_frame(16'(lim), 1'b0);
    rx_frame(16'(lim + 1), 1'b1);
    rd(ADDR_RX_STATUS, v);
    ok(v === 16'h0001, "oversize status");
    rd(ADDR_RX_STATUS, v);
    ok(v === 16'h0000, "status clear on read");
    wr(ADDR_FRAME_LIMIT, 16'(lim + 4));
    rx_frame(16'(lim + 4), 1'b0);
    $display("Test done: frame limit");
    report_and_stop();
  end
endmodule : tb_top
